/* hdl/cat_timing_top.sv */
// Purpose: channel access timing: ifs, backoff, nav, tsf, tbtt, sleep
// Assumes: sequencer inputs are on i_clock; phy busy and slow clock are pins
// Notes:   this logic stays clocked while o_mac_clk_en gates the mac clock
//
// Behaviour
// - start ifs timer when phy activity ends
// - ifs timer gives transmit engine start trigger
// - one backoff engine per access category, slotted
// - notify transmit engine when backoff hits zero
// - programmed priority picks one simultaneous winner
// - power save stops mac clock, sleep countdown
// - sleep timer expiry restores normal operation
// - keep running tsf while awake and tbtt from it
// - load tsf from received timestamp on command
// - trigger when tsf reaches programmed offsets
// - nav timer updated from received duration
// - nav acts as virtual carrier busy
`default_nettype none

module cat_timing_top #(
  parameter int unsigned NUM_AC  = cat_pkg::NUM_AC,
  parameter int unsigned NUM_OFS = cat_pkg::NUM_OFS
) (
  // clock and reset
  input  wire logic                        i_clock,
  input  wire logic                        i_rstn,
  // phy and slow clock pins
  input  wire logic                        i_phy_busy,
  input  wire logic                        i_slow_clock,
  // interframe and slot setup
  input  wire logic [cat_pkg::IFS_W-1:0]   i_ifs_cycles,
  input  wire logic [cat_pkg::SLOT_W-1:0]  i_slot_cycles,
  // backoff control
  input  wire logic [NUM_AC-1:0]           i_bo_load,
  input  wire logic [cat_pkg::BO_W-1:0]    i_bo_value,
  input  wire logic                        i_prio_low_first,
  // nav control
  input  wire logic                        i_nav_update,
  input  wire logic                        i_nav_clear,
  input  wire logic [cat_pkg::NAV_W-1:0]   i_nav_duration,
  // tsf and tbtt control
  input  wire logic                        i_tsf_load,
  input  wire logic [cat_pkg::TSF_W-1:0]   i_tsf_value,
  input  wire logic                        i_tbtt_load,
  input  wire logic [cat_pkg::TSF_W-1:0]   i_tbtt_value,
  input  wire logic [cat_pkg::BCN_W-1:0]   i_bcn_interval,
  input  wire logic [NUM_OFS-1:0]          i_ofs_load,
  input  wire logic [cat_pkg::OFS_W-1:0]   i_ofs_value,
  // sleep control
  input  wire logic                        i_sleep_start,
  input  wire logic [cat_pkg::SLEEP_W-1:0] i_sleep_count,
  // transmit engine
  output logic                             o_tx_trigger,
  output logic                             o_bo_win,
  output logic [$clog2(NUM_AC)-1:0]        o_bo_win_ac,
  // timekeeping
  output logic                             o_nav_busy,
  output logic [cat_pkg::TSF_W-1:0]        o_tsf,
  output logic                             o_tbtt,
  output logic [NUM_OFS-1:0]               o_ofs_trig,
  // power save
  output logic                             o_mac_clk_en,
  output logic                             o_wake
);

  localparam int unsigned AC_W   = $clog2(NUM_AC);
  localparam int unsigned US_W   = cat_pkg::US_CNT_W;
  localparam int unsigned IFS_W  = cat_pkg::IFS_W;
  localparam int unsigned SLOT_W = cat_pkg::SLOT_W;
  localparam int unsigned NAV_W  = cat_pkg::NAV_W;
  localparam int unsigned TSF_W  = cat_pkg::TSF_W;
  localparam int unsigned OFS_W  = cat_pkg::OFS_W;
  localparam int unsigned SLP_W  = cat_pkg::SLEEP_W;
  localparam logic [US_W-1:0] US_MAX = US_W'(cat_pkg::CYC_PER_US - 1);

  typedef struct packed {
    logic                            busy_s1;
    logic                            busy_s2;
    logic                            slow_s1;
    logic                            slow_s2;
    logic                            slow_prev;
    logic [US_W-1:0]                 us_cnt;
    cat_pkg::cat_ifs_e               ifs;
    logic [IFS_W-1:0]                ifs_cnt;
    logic [SLOT_W-1:0]               slot_cnt;
    logic                            tx_trig;
    logic                            bo_win;
    logic [AC_W-1:0]                 bo_ac;
    logic [NAV_W-1:0]                nav;
    logic [TSF_W-1:0]                tsf;
    logic [TSF_W-1:0]                tbtt_at;
    logic                            tbtt;
    logic [NUM_OFS-1:0][OFS_W-1:0]   ofs;
    logic [NUM_OFS-1:0]              ofs_trig;
    cat_pkg::cat_pm_e                pm;
    logic [SLP_W-1:0]                sleep_cnt;
    logic                            wake;
  } cat_top_s;

  cat_top_s          st_q;
  cat_top_s          st_d;
  logic [NUM_AC-1:0] zero_mask;
  logic              awake;
  logic              us_tick;
  logic              chan_busy;
  logic              slot_end;
  logic              slot_idle_end;

  // highest or lowest ready category, as the sequencer chose
  function automatic logic [AC_W-1:0] pick_ac(input logic [NUM_AC-1:0] m,
                                               input logic low_first);
    logic [AC_W-1:0] r;
    r = '0;
    for (int i = 0; i < NUM_AC; i++) begin
      if (m[i] && (!low_first || (m & ((NUM_AC'(1) << i) - NUM_AC'(1))) == '0)) begin
        r = AC_W'(i);
      end
    end
    return r;
  endfunction

  // ------------------------------------------------------------------
  // backoff engines
  // ------------------------------------------------------------------
  for (genvar g = 0; g < NUM_AC; g++) begin : g_bo
    cat_backoff_engine #(
      .CNT_W (cat_pkg::BO_W)
    ) u_bo (
      .i_clock         (i_clock),
      .i_rstn          (i_rstn),
      .i_load          (i_bo_load[g]),
      .i_load_value    (i_bo_value),
      .i_slot_idle_end (slot_idle_end),
      .o_count         (),
      .o_zero_pulse    (zero_mask[g])
    );
  end

  // ------------------------------------------------------------------
  // shared conditions
  // ------------------------------------------------------------------
  assign awake         = (st_q.pm == cat_pkg::PM_AWAKE);
  assign us_tick       = awake && (st_q.us_cnt == US_MAX);
  assign chan_busy     = st_q.busy_s2 || (st_q.nav != '0);
  // slot length below one cycle is treated as one cycle
  assign slot_end      = awake && (st_q.ifs == cat_pkg::IFS_IDLE) &&
                         (st_q.slot_cnt + SLOT_W'(1) >= i_slot_cycles);
  assign slot_idle_end = slot_end && !chan_busy;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    st_d           = st_q;
    st_d.tx_trig   = 1'b0;
    st_d.bo_win    = 1'b0;
    st_d.tbtt      = 1'b0;
    st_d.ofs_trig  = '0;
    st_d.wake      = 1'b0;
    st_d.busy_s1   = i_phy_busy;
    st_d.busy_s2   = st_q.busy_s1;
    st_d.slow_s1   = i_slow_clock;
    st_d.slow_s2   = st_q.slow_s1;
    st_d.slow_prev = st_q.slow_s2;

    // microsecond base; frozen while the mac sleeps
    if (awake) begin
      st_d.us_cnt = us_tick ? '0 : st_q.us_cnt + US_W'(1);
    end

    // nav only ever grows from a received duration
    if (i_nav_clear) begin
      st_d.nav = '0;
    end else if (i_nav_update && (i_nav_duration > st_q.nav)) begin
      st_d.nav = i_nav_duration;
    end else if (us_tick && (st_q.nav != '0)) begin
      st_d.nav = st_q.nav - NAV_W'(1);
    end

    case (st_q.ifs)
      cat_pkg::IFS_BUSY: begin
        if (!chan_busy) begin
          st_d.ifs     = cat_pkg::IFS_COUNT;
          st_d.ifs_cnt = i_ifs_cycles;
        end
      end
      cat_pkg::IFS_COUNT: begin
        if (chan_busy) begin
          st_d.ifs = cat_pkg::IFS_BUSY;
        end else if (st_q.ifs_cnt <= IFS_W'(1)) begin
          st_d.ifs      = cat_pkg::IFS_IDLE;
          st_d.tx_trig  = 1'b1;
          st_d.slot_cnt = '0;
        end else begin
          st_d.ifs_cnt = st_q.ifs_cnt - IFS_W'(1);
        end
      end
      cat_pkg::IFS_IDLE: begin
        if (chan_busy) begin
          st_d.ifs = cat_pkg::IFS_BUSY;
        end else if (awake) begin
          st_d.slot_cnt = slot_end ? '0 : st_q.slot_cnt + SLOT_W'(1);
        end
      end
      default: begin
        st_d.ifs = cat_pkg::IFS_BUSY;
      end
    endcase

    if (zero_mask != '0) begin
      st_d.bo_win = 1'b1;
      st_d.bo_ac  = pick_ac(zero_mask, i_prio_low_first);
    end

    // tsf stops while asleep; sequencer reloads it on wake
    if (i_tsf_load) begin
      st_d.tsf = i_tsf_value;
    end else if (us_tick) begin
      st_d.tsf = st_q.tsf + TSF_W'(1);
    end

    if (i_tbtt_load) begin
      st_d.tbtt_at = i_tbtt_value;
    end else if (us_tick && (st_q.tsf == st_q.tbtt_at)) begin
      st_d.tbtt    = 1'b1;
      st_d.tbtt_at = st_q.tbtt_at + TSF_W'(i_bcn_interval);
    end

    for (int k = 0; k < NUM_OFS; k++) begin
      if (i_ofs_load[k]) begin
        st_d.ofs[k] = i_ofs_value;
      end
      if (us_tick && (st_q.tsf[OFS_W-1:0] == st_q.ofs[k])) begin
        st_d.ofs_trig[k] = 1'b1;
      end
    end

    case (st_q.pm)
      cat_pkg::PM_AWAKE: begin
        if (i_sleep_start) begin
          st_d.pm        = cat_pkg::PM_ASLEEP;
          st_d.sleep_cnt = i_sleep_count;
        end
      end
      cat_pkg::PM_ASLEEP: begin
        if (st_q.slow_s2 && !st_q.slow_prev) begin
          if (st_q.sleep_cnt <= SLP_W'(1)) begin
            st_d.pm   = cat_pkg::PM_AWAKE;
            st_d.wake = 1'b1;
          end else begin
            st_d.sleep_cnt = st_q.sleep_cnt - SLP_W'(1);
          end
        end
      end
      default: begin
        st_d.pm = cat_pkg::PM_AWAKE;
      end
    endcase
  end

  // zero encodes IFS_BUSY and PM_AWAKE
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign o_tx_trigger = st_q.tx_trig;
  assign o_bo_win     = st_q.bo_win;
  assign o_bo_win_ac  = st_q.bo_ac;
  assign o_nav_busy   = (st_q.nav != '0);
  assign o_tsf        = st_q.tsf;
  assign o_tbtt       = st_q.tbtt;
  assign o_ofs_trig   = st_q.ofs_trig;
  assign o_mac_clk_en = awake;
  assign o_wake       = st_q.wake;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  sequence s_medium_freed;
    (st_q.ifs == cat_pkg::IFS_BUSY) && !chan_busy;
  endsequence

  sequence s_sleep_enter;
    awake && i_sleep_start;
  endsequence

  a_ifs_start: assert property (
    s_medium_freed |=> (st_q.ifs == cat_pkg::IFS_COUNT) && (st_q.ifs_cnt == $past(i_ifs_cycles)))
    else $error("ifs timer not started when medium went quiet");

  a_tx_trigger_src: assert property (
    o_tx_trigger |-> $past(st_q.ifs == cat_pkg::IFS_COUNT) && !$past(chan_busy)
      && st_q.ifs == cat_pkg::IFS_IDLE)
    else $error("transmit trigger without ifs expiry");

  a_bo_notify: assert property (
    (zero_mask != '0) |=> o_bo_win)
    else $error("backoff zero not reported");

  a_bo_winner: assert property (
    ((zero_mask != '0) && !i_prio_low_first) |=> ($past(zero_mask) >> o_bo_win_ac) == NUM_AC'(1))
    else $error("winner is not the highest ready category");

  a_slot_virtual: assert property (
    (o_nav_busy && st_q.ifs == cat_pkg::IFS_IDLE) |=> st_q.ifs == cat_pkg::IFS_BUSY)
    else $error("nav busy did not block the medium");

  a_sleep_clock: assert property (
    s_sleep_enter |=> !o_mac_clk_en ##1 (!o_mac_clk_en || o_wake))
    else $error("mac clock not stopped on sleep");

  a_wake_restore: assert property (
    o_wake |-> o_mac_clk_en && $past(st_q.pm) == cat_pkg::PM_ASLEEP && $past(st_q.sleep_cnt) <= 1)
    else $error("wake without sleep expiry");

  a_tsf_frozen: assert property (
    (!o_mac_clk_en && !i_tsf_load) |=> o_tsf == $past(o_tsf))
    else $error("tsf moved while asleep");

  a_tsf_run: assert property (
    (us_tick && !i_tsf_load) |=> o_tsf == $past(o_tsf) + TSF_W'(1))
    else $error("tsf did not advance on microsecond tick");

  a_tsf_adopt: assert property (
    i_tsf_load |=> o_tsf == $past(i_tsf_value))
    else $error("tsf did not adopt timestamp");

  a_ofs_trigger: assert property (
    (o_ofs_trig != '0) |-> $past(us_tick))
    else $error("offset trigger off a microsecond tick");

  a_nav_update: assert property (
    (i_nav_update && !i_nav_clear && i_nav_duration > st_q.nav)
      |=> st_q.nav == $past(i_nav_duration))
    else $error("nav not raised to received duration");

endmodule

`default_nettype wire

/* shared/cat_pkg.sv */
// Purpose: shared constants and types for the channel access timing block
// Assumes: mac clock of 25 MHz, tsf counted in microseconds
// Notes:   every timer width lives here so the two design files agree
`default_nettype none

package cat_pkg;

  // ------------------------------------------------------------------
  // clock and time base
  // ------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned US_NS         = 1000;
  localparam int unsigned CYC_PER_US    = US_NS / CLK_PERIOD_NS;
  localparam int unsigned US_CNT_W      = $clog2(CYC_PER_US);

  // ------------------------------------------------------------------
  // timer widths
  // ------------------------------------------------------------------
  localparam int unsigned BO_W    = 10;
  localparam int unsigned IFS_W   = 12;
  localparam int unsigned SLOT_W  = 12;
  localparam int unsigned NAV_W   = 16;
  localparam int unsigned TSF_W   = 64;
  localparam int unsigned BCN_W   = 32;
  localparam int unsigned OFS_W   = 32;
  localparam int unsigned SLEEP_W = 32;
  localparam int unsigned NUM_AC  = 4;
  localparam int unsigned NUM_OFS = 2;

  // ------------------------------------------------------------------
  // state encodings
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    IFS_BUSY,
    IFS_COUNT,
    IFS_IDLE
  } cat_ifs_e;

  typedef enum logic {
    PM_AWAKE,
    PM_ASLEEP
  } cat_pm_e;

endpackage

`default_nettype wire

/* hdl/cat_backoff_engine.sv */
// Purpose: one backoff counter for a single access category
// Assumes: i_slot_idle_end pulses once per slot that stayed idle
// Notes:   o_zero_pulse fires once per load, when the count reaches zero
`default_nettype none

module cat_backoff_engine #(
  parameter int unsigned CNT_W = cat_pkg::BO_W
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rstn,
  // load from sequencer
  input  wire logic             i_load,
  input  wire logic [CNT_W-1:0] i_load_value,
  // slot timing
  input  wire logic             i_slot_idle_end,
  // state
  output logic      [CNT_W-1:0] o_count,
  output logic                  o_zero_pulse
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             armed;
    logic             zero_pulse;
  } cat_bo_s;

  cat_bo_s st_q;
  cat_bo_s st_d;

  // ------------------------------------------------------------------
  // count
  // ------------------------------------------------------------------
  always_comb begin
    st_d            = st_q;
    st_d.zero_pulse = 1'b0;
    if (i_load) begin
      st_d.count      = i_load_value;
      st_d.armed      = (i_load_value != '0);
      st_d.zero_pulse = (i_load_value == '0);
    end else if (i_slot_idle_end && st_q.armed) begin
      // busy slots never reach here, so the count holds across them
      st_d.count = st_q.count - CNT_W'(1);
      if (st_q.count == CNT_W'(1)) begin
        st_d.armed      = 1'b0;
        st_d.zero_pulse = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_count      = st_q.count;
  assign o_zero_pulse = st_q.zero_pulse;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  a_bo_hold_count: assert property (
    (!i_load && !i_slot_idle_end) |=> o_count == $past(o_count))
    else $error("backoff count moved outside an idle slot end");

  a_bo_step_down: assert property (
    (!i_load && i_slot_idle_end && st_q.armed) |=> o_count == $past(o_count) - CNT_W'(1))
    else $error("backoff count did not step at idle slot end");

  a_bo_zero_note: assert property (
    o_zero_pulse |-> o_count == '0 ##1 (!o_zero_pulse || $past(i_load)))
    else $error("zero notice without zero count");

endmodule

`default_nettype wire

/* verif/cat_far_model.sv */
// Purpose: stand-in for the phy activity pin and the sleep oscillator
// Assumes: bursts are requested by the bench on i_clock
// Notes:   slow clock runs free, as a sleep oscillator does
`default_nettype none

module cat_far_model (
  // clock
  input  wire logic       i_clock,
  // burst request
  input  wire logic       i_go,
  input  wire logic [7:0] i_len,
  // pins
  output logic            o_phy_busy,
  output logic            o_slow_clock
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] left_q = 8'h00;

  // 400 ns period, so every edge lands on a falling i_clock edge in this bench
  initial begin
    o_slow_clock = 1'b0;
    forever #200 o_slow_clock = ~o_slow_clock;
  end

  // busy changes just after an edge, like a real medium report
  always @(posedge i_clock) begin
    if (i_go) begin
      left_q <= i_len;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end

  assign o_phy_busy = (left_q != 8'h00);
endmodule

`default_nettype wire

/* verif/tb_top.sv */
// Purpose: self-checking bench for the channel access timing block
// Assumes: 25 MHz clock, microsecond tick every 25 cycles
// Notes:   the bench plays sequencer and transmit engine
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic        i_clock, i_rstn, phy_busy, slow_clock, go, prio_low_first;
  logic        nav_update, nav_clear, tsf_load, tbtt_load, sleep_start;
  logic        tx_trigger, bo_win, nav_busy, tbtt, mac_clk_en, wake;
  logic [7:0]  len;
  logic [11:0] ifs_cycles, slot_cycles;
  logic [3:0]  bo_load;
  logic [9:0]  bo_value;
  logic [15:0] nav_duration;
  logic [63:0] tsf_value, tbtt_value, tsf, tsf_seen;
  logic [31:0] bcn_interval, ofs_value, sleep_count;
  logic [1:0]  ofs_load, bo_win_ac, ofs_trig;
  int          fail_count, total_checks, cycles, n;

  cat_far_model far_u (.i_clock(i_clock), .i_go(go), .i_len(len),
    .o_phy_busy(phy_busy), .o_slow_clock(slow_clock));

  cat_timing_top dut_u (.i_clock(i_clock), .i_rstn(i_rstn),
    .i_phy_busy(phy_busy), .i_slow_clock(slow_clock),
    .i_ifs_cycles(ifs_cycles), .i_slot_cycles(slot_cycles),
    .i_bo_load(bo_load), .i_bo_value(bo_value), .i_prio_low_first(prio_low_first),
    .i_nav_update(nav_update), .i_nav_clear(nav_clear), .i_nav_duration(nav_duration),
    .i_tsf_load(tsf_load), .i_tsf_value(tsf_value), .i_tbtt_load(tbtt_load),
    .i_tbtt_value(tbtt_value), .i_bcn_interval(bcn_interval), .i_ofs_load(ofs_load),
    .i_ofs_value(ofs_value), .i_sleep_start(sleep_start), .i_sleep_count(sleep_count),
    .o_tx_trigger(tx_trigger), .o_bo_win(bo_win), .o_bo_win_ac(bo_win_ac),
    .o_nav_busy(nav_busy), .o_tsf(tsf), .o_tbtt(tbtt), .o_ofs_trig(ofs_trig),
    .o_mac_clk_en(mac_clk_en), .o_wake(wake));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: return tx_trigger;
      1: return bo_win;
      2: return tbtt;
      3: return ofs_trig[1];
      default: return wake;
    endcase
  endfunction

  // bounded wait for a pulse; c is the edge count when seen or lim
  task automatic await(input int k, input int lim, output int c);
    c = 0;
    do begin
      @(posedge i_clock);
      #1;
      c++;
    end while (pick(k) !== 1'b1 && c < lim);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_ifs;
    @(posedge i_clock); len <= 8'h0a; go <= 1'b1;
    @(posedge i_clock); go <= 1'b0;
    await(0, 15, n);
    chk(n, 15);
    chk(tx_trigger, 1'b0);
    // second burst lands mid count, so that count must be dropped
    @(posedge i_clock); len <= 8'h08; go <= 1'b1;
    @(posedge i_clock); go <= 1'b0;
    await(0, 60, n);
    chk(tx_trigger, 1'b1);
    chk(n >= 29 && n <= 33, 1'b1);
    $display("ifs test done");
  endtask

  task automatic t_bo(input logic lf, input logic [1:0] ac);
    @(posedge i_clock); prio_low_first <= lf; bo_value <= 10'h002; bo_load <= 4'b0110;
    @(posedge i_clock); bo_load <= 4'b0000;
    await(1, 30, n);
    chk(bo_win, 1'b1);
    chk(bo_win_ac, ac);
    chk(n >= 6, 1'b1);
    @(posedge i_clock); #1;
    chk(bo_win, 1'b0);
    $display("backoff test done");
  endtask

  task automatic t_nav;
    @(posedge i_clock); nav_duration <= 16'h0004; nav_update <= 1'b1;
    bo_value <= 10'h001; bo_load <= 4'b0001;
    @(posedge i_clock); nav_duration <= 16'h0001; bo_load <= 4'b0000;
    @(posedge i_clock); nav_update <= 1'b0;
    #1 chk(nav_busy, 1'b1);
    await(1, 40, n);
    chk(n, 40);
    chk(bo_win, 1'b0);
    chk(nav_busy, 1'b1);
    await(1, 200, n);
    chk(bo_win, 1'b1);
    chk(bo_win_ac, 2'h0);
    @(posedge i_clock); nav_duration <= 16'h0064; nav_update <= 1'b1;
    @(posedge i_clock); nav_update <= 1'b0; nav_clear <= 1'b1;
    @(posedge i_clock); nav_clear <= 1'b0;
    @(posedge i_clock); #1;
    chk(nav_busy, 1'b0);
    $display("nav test done");
  endtask

  task automatic t_tsf;
    @(posedge i_clock); tsf_value <= 64'h100; tsf_load <= 1'b1; tbtt_value <= 64'h103;
    tbtt_load <= 1'b1; ofs_value <= 32'h105; ofs_load <= 2'b10; bcn_interval <= 32'h2;
    @(posedge i_clock); tsf_load <= 1'b0; tbtt_load <= 1'b0; ofs_load <= 2'b00;
    #1 chk(tsf, 64'h100);
    repeat (25) @(posedge i_clock);
    #1 chk(tsf, 64'h101);
    await(2, 100, n);
    chk(tbtt, 1'b1);
    await(3, 60, n);
    chk(ofs_trig, 2'b10);
    chk(tbtt, 1'b1);
    $display("tsf test done");
  endtask

  task automatic t_sleep;
    @(posedge i_clock); sleep_count <= 32'h3; sleep_start <= 1'b1;
    @(posedge i_clock); sleep_start <= 1'b0;
    #1 chk(mac_clk_en, 1'b0);
    tsf_seen = tsf;
    await(4, 120, n);
    chk(wake, 1'b1);
    chk(mac_clk_en, 1'b1);
    chk(tsf, tsf_seen);
    chk(n >= 15, 1'b1);
    @(posedge i_clock); tsf_value <= tsf_seen + 64'h2; tsf_load <= 1'b1;
    @(posedge i_clock); tsf_load <= 1'b0;
    #1 chk(tsf, tsf_seen + 64'h2);
    $display("sleep test done");
  endtask

  // ----------------------------------------
  // clock, timeout, main sequence
  // ----------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end

  // whole run needs well under a thousand cycles
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      complete_run();
    end
  end

  initial begin
    i_rstn = 1'b0; go = 1'b0; len = 8'h00; ifs_cycles = 12'h014; slot_cycles = 12'h004;
    bo_load = 4'h0; bo_value = 10'h000; prio_low_first = 1'b0; nav_update = 1'b0;
    nav_clear = 1'b0; nav_duration = 16'h0000; tsf_load = 1'b0; tsf_value = 64'h0;
    tbtt_load = 1'b0; tbtt_value = 64'h0; bcn_interval = 32'h0; ofs_load = 2'b00;
    ofs_value = 32'hffff0000; sleep_start = 1'b0; sleep_count = 32'h0;
    fail_count = 0; total_checks = 0; cycles = 0;
    repeat (4) @(posedge i_clock);
    #1 chk(tsf, 64'h0);
    chk(mac_clk_en, 1'b1);
    chk(nav_busy, 1'b0);
    @(posedge i_clock); i_rstn <= 1'b1;
    repeat (40) @(posedge i_clock);
    t_ifs();
    t_bo(1'b1, 2'h1);
    t_bo(1'b0, 2'h2);
    t_nav();
    t_tsf();
    t_sleep();
    complete_run();
  end
endmodule

`default_nettype wire
